// ===== verilog/i2c_byte_engine_registers.sv
// register file and core-side control of the two-wire serial interface
// Overview of operation
// - hardware sets the interrupt flag on service requests, clears stop bit on stop.
// - stop bit forced to zero while interface enable is zero.
// - status register is 8-bit read-only, low three bits zero, code above.
// - 26 codes exist; f8h means idle with no interrupt pending.
// - reset loads the status register with f8h.
// - entering any non-idle state raises the flag; its code is presented only if the flag was clear.
// - status code holds until firmware clears the interrupt flag.
// - status follows the interrupt flag one cpu clock later.
// - cpu writes data only while flag set; a byte finishing on the bus still overwrites it then.
// - bits go out msb first; first received bit lands in bit 7.
// - bus bits shift in while shifting out; data holds last bus byte.
// - lost arbitration keeps the correct received byte in data.
// - data plus hidden ack flag form a nine-bit shift path.
// - bits enter on rising serial clock, leave on falling serial clock.
// - after a received byte, ack is driven during the ninth pulse.
// - cpu write puts bit 7 in the output buffer at once.
// - own address never changed by hardware, ignored while master.
// - upper seven bits are slave address; lsb enables general call 00h.
// - in power-down, wake match acks, holds scl, picks direction, requests wake.
// - with aa low, no ack for next byte and addresses ignored; a power-down wake match still acks.
`timescale 1ns/1ns
`default_nettype none
`include "i2c_regs_consts.svh"
module i2c_byte_engine_registers #(
  parameter int CODE_W = 5,
  parameter int SYNC_STAGES = 2
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [15:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  input wire logic scl_clk,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic scl_out,
  output logic scl_oe,
  input wire logic bus_event,
  input wire logic [4:0] bus_event_code,
  input wire logic stop_seen,
  input wire logic master_mode,
  input wire logic rx_mode,
  input wire logic tx_mode,
  input wire logic addr_phase,
  input wire logic power_down,
  output logic interface_enable_bit,
  output logic start_request_bit,
  output logic stop_request_bit,
  output logic ack_assert_bit,
  output logic serial_irq,
  output logic byte_done,
  output logic ack_seen,
  output logic own_addr_hit,
  output logic wake_request,
  output logic wake_slave_tx
);
  if (CODE_W != 5 || SYNC_STAGES != 2) begin : g_check
    $error("status code width must be 5 and sync depth 2");
  end

  shift_link_if lnk ();

  logic [7:0] ctrl_r;
  logic si_r;
  logic si_d_r;
  logic stop_r;
  logic [4:0] code_r;
  logic [7:0] sta_r;
  logic [7:0] dat_r;
  logic tx_first_r;
  logic [7:0] adr_r;
  logic [7:0] wake_r;
  logic [7:0] rdata_r;
  logic [2:0] done_s_r;
  logic [1:0] wake_s_r;
  logic hit_r;
  logic ack_r;
  logic wreq_r;
  logic wdir_r;
  i2c_regs_pkg::wake_state_e wst_r;
  logic wr_ctrl;
  logic wr_dat;
  logic wr_adr;
  logic wr_wake;
  logic done_p;
  logic set_si;

  assign wr_ctrl = sfr_wr && sfr_addr == `OFF_CTRL;
  assign wr_dat = sfr_wr && sfr_addr == `OFF_DAT;
  assign wr_adr = sfr_wr && sfr_addr == `OFF_ADR;
  assign wr_wake = sfr_wr && sfr_addr == `OFF_WAKE;
  assign set_si = bus_event && bus_event_code != `CODE_IDLE;

  // control bits other than si and stop are plain storage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= `RST_CTRL;
    end else if (wr_ctrl) begin
      ctrl_r <= sfr_wdata;
    end
  end

  // hardware set beats a same-cycle firmware clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      si_r <= 1'b0;
    end else if (set_si) begin
      si_r <= 1'b1;
    end else if (wr_ctrl) begin
      si_r <= sfr_wdata[`CTRL_SI_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stop_r <= 1'b0;
    end else if (!ctrl_r[`CTRL_ENS_BIT] || stop_seen || (wr_ctrl && !sfr_wdata[`CTRL_ENS_BIT])) begin
      // a write that turns the interface off takes the stop bit with it
      stop_r <= 1'b0;
    end else if (wr_ctrl) begin
      stop_r <= sfr_wdata[`CTRL_STO_BIT];
    end
  end

  // code of an event arriving while si is set is dropped, first one stands
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      code_r <= `CODE_IDLE;
    end else if (set_si && !si_r) begin
      code_r <= bus_event_code;
    end
  end

  // status trails si by one clock, so it is valid one clock after si is set
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      si_d_r <= 1'b0;
      sta_r <= `STA_IDLE;
    end else begin
      si_d_r <= si_r;
      if (si_r && !si_d_r) begin
        sta_r <= {code_r, 3'b000};
      end else if (!si_r && si_d_r) begin
        sta_r <= `STA_IDLE;
      end
    end
  end

  // byte completion event from the serial clock side
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      done_s_r <= 3'b000;
      wake_s_r <= 2'b00;
    end else begin
      done_s_r <= {done_s_r[1:0], lnk.done_tgl};
      wake_s_r <= {wake_s_r[0], lnk.wake_hit};
    end
  end
  assign done_p = done_s_r[2] ^ done_s_r[1];

  // rx byte is held in the link until the next byte ends, so it is safe to copy
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dat_r <= `RST_DAT;
      tx_first_r <= 1'b1;
      hit_r <= 1'b0;
      ack_r <= 1'b1;
    end else if (done_p) begin
      dat_r <= lnk.rx_byte;
      tx_first_r <= lnk.rx_byte[7];
      hit_r <= !master_mode && i2c_regs_pkg::addr_hit(lnk.rx_byte, adr_r);
      ack_r <= lnk.rx_ack;
    end else if (wr_dat && si_r) begin
      dat_r <= sfr_wdata;
      tx_first_r <= sfr_wdata[7];
    end
  end

  // own address is software-only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      adr_r <= `RST_ADR;
    end else if (wr_adr) begin
      adr_r <= sfr_wdata;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wake_r <= `RST_WAKE;
    end else if (wr_wake) begin
      wake_r <= sfr_wdata;
    end
  end

  // wake holds scl until firmware turns the wake block off; a fast master may still
  // see one short high phase since the hit crosses two clocks late
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wst_r <= i2c_regs_pkg::WK_OFF;
      wreq_r <= 1'b0;
      wdir_r <= 1'b0;
    end else begin
      case (wst_r)
        i2c_regs_pkg::WK_OFF: begin
          wreq_r <= 1'b0;
          if (wake_r[`WAKE_EN_BIT]) begin
            wst_r <= i2c_regs_pkg::WK_ARMED;
          end
        end
        i2c_regs_pkg::WK_ARMED: begin
          if (!wake_r[`WAKE_EN_BIT]) begin
            wst_r <= i2c_regs_pkg::WK_OFF;
          end else if (wake_s_r[1]) begin
            wst_r <= i2c_regs_pkg::WK_HOLD;
            wreq_r <= 1'b1;
            wdir_r <= lnk.rx_byte[0];
          end
        end
        i2c_regs_pkg::WK_HOLD: begin
          if (!wake_r[`WAKE_EN_BIT]) begin
            wst_r <= i2c_regs_pkg::WK_OFF;
            wreq_r <= 1'b0;
          end
        end
        default: begin
          wst_r <= i2c_regs_pkg::WK_OFF;
        end
      endcase
    end
  end

  // ack flag never appears on the read path
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 8'h00;
    end else if (sfr_rd) begin
      case (sfr_addr)
        `OFF_CTRL: rdata_r <= {ctrl_r[7:5], stop_r, si_r, ctrl_r[2:0]};
        `OFF_STA: rdata_r <= sta_r;
        `OFF_DAT: rdata_r <= dat_r;
        `OFF_ADR: rdata_r <= adr_r;
        `OFF_WAKE: rdata_r <= wake_r;
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  assign lnk.tx_byte = dat_r;
  assign lnk.tx_first = tx_first_r;
  assign lnk.own_addr = adr_r;
  always_comb begin
    lnk.cfg = '0;
    lnk.cfg[`CFG_ENS] = ctrl_r[`CTRL_ENS_BIT];
    lnk.cfg[`CFG_AA] = ctrl_r[`CTRL_AA_BIT];
    lnk.cfg[`CFG_MST] = master_mode;
    lnk.cfg[`CFG_RX] = rx_mode;
    lnk.cfg[`CFG_TX] = tx_mode;
    lnk.cfg[`CFG_ADRPH] = addr_phase;
    lnk.cfg[`CFG_PD] = power_down;
    lnk.cfg[`CFG_WEN] = wake_r[`WAKE_EN_BIT];
    lnk.cfg[`CFG_WWR] = wake_r[`WAKE_WR_BIT];
    lnk.cfg[`CFG_WRD] = wake_r[`WAKE_RD_BIT];
  end

  i2c_shift_path u_shift (
    .scl_clk(scl_clk),
    .nrst(nrst),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .lk(lnk)
  );

  assign sfr_rdata = rdata_r;
  assign scl_out = 1'b0;
  assign scl_oe = wst_r == i2c_regs_pkg::WK_HOLD;
  assign interface_enable_bit = ctrl_r[`CTRL_ENS_BIT];
  assign start_request_bit = ctrl_r[`CTRL_STA_BIT];
  assign stop_request_bit = stop_r;
  assign ack_assert_bit = ctrl_r[`CTRL_AA_BIT];
  assign serial_irq = si_r;
  assign byte_done = done_p;
  assign ack_seen = ack_r;
  assign own_addr_hit = hit_r;
  assign wake_request = wreq_r;
  assign wake_slave_tx = wdir_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence si_rise_s;
    !si_r ##1 si_r;
  endsequence
  sequence si_fall_s;
    si_r ##1 !si_r;
  endsequence

  stop_on_bus_a: assert property (stop_seen |=> !stop_r)
    else $error("stop bit survived a stop condition");
  stop_when_off_a: assert property (!ctrl_r[`CTRL_ENS_BIT] |=> !stop_request_bit)
    else $error("stop bit set while disabled");
  status_low_zero_a: assert property (sta_r[2:0] == 3'b000)
    else $error("status low bits not zero");
  event_sets_si_a: assert property (set_si |=> serial_irq)
    else $error("service request did not raise flag");
  status_follows_si_a: assert property (si_rise_s |=> sta_r == {$past(code_r), 3'b000})
    else $error("status not loaded one clock after flag");
  status_idle_after_a: assert property (si_fall_s |=> sta_r == `STA_IDLE)
    else $error("status not idle after flag cleared");
  status_holds_a: assert property (si_r && si_d_r && $past(si_d_r) |-> $stable(sta_r))
    else $error("status changed while flag set");
  data_stable_a: assert property (si_r && !done_p && !wr_dat |=> $stable(dat_r))
    else $error("data changed while flag set");
  addr_untouched_a: assert property (!wr_adr |=> $stable(adr_r))
    else $error("own address changed by hardware");
  wake_hold_a: assert property (wake_request |-> scl_oe && $past(wake_r[`WAKE_EN_BIT]))
    else $error("wake request without clock hold");
endmodule // i2c_byte_engine_registers
`default_nettype wire

// ===== verilog/i2c_regs_consts.svh
// offsets, field positions, reset values and codes of the serial interface registers
`ifndef I2C_REGS_CONSTS_SVH
`define I2C_REGS_CONSTS_SVH
`define OFF_CTRL 16'h00d8
`define OFF_STA 16'h00d9
`define OFF_DAT 16'h00da
`define OFF_ADR 16'h00db
`define OFF_WAKE 16'h610a
`define CTRL_AA_BIT 2
`define CTRL_SI_BIT 3
`define CTRL_STO_BIT 4
`define CTRL_STA_BIT 5
`define CTRL_ENS_BIT 6
`define WAKE_EN_BIT 0
`define WAKE_WR_BIT 1
`define WAKE_RD_BIT 2
`define RST_CTRL 8'h00
`define RST_DAT 8'h00
`define RST_ADR 8'h00
`define RST_WAKE 8'h00
`define STA_IDLE 8'hf8
`define CODE_IDLE 5'h1f
`define GC_ADDR 7'h00
`define CFG_ENS 0
`define CFG_AA 1
`define CFG_MST 2
`define CFG_RX 3
`define CFG_TX 4
`define CFG_ADRPH 5
`define CFG_PD 6
`define CFG_WEN 7
`define CFG_WWR 8
`define CFG_WRD 9
`define CFG_W 10
`define BIT_LAST 4'h8
`endif

// ===== verilog/i2c_regs_pkg.sv
// types and shared decode for the serial interface register block
package i2c_regs_pkg;
  typedef logic [4:0] code_t;
  typedef logic [9:0] cfg_t;
  typedef enum logic [1:0] {WK_OFF, WK_ARMED, WK_HOLD} wake_state_e;
  // own address or general call on a received first byte
  function automatic logic addr_hit(input logic [7:0] rx, input logic [7:0] own);
    addr_hit = (rx[7:1] == own[7:1]) || (own[0] && rx[7:1] == 7'h00 && !rx[0]);
  endfunction
endpackage

// ===== verilog/shift_link_if.sv
// carrier between the register side and the serial clock side
`timescale 1ns/1ns
`default_nettype none
interface shift_link_if;
  logic [7:0] tx_byte;
  logic tx_first;
  i2c_regs_pkg::cfg_t cfg;
  logic [7:0] own_addr;
  logic [7:0] rx_byte;
  logic rx_ack;
  logic done_tgl;
  logic wake_hit;
  modport core (output tx_byte, output tx_first, output cfg, output own_addr,
                input rx_byte, input rx_ack, input done_tgl, input wake_hit);
  modport link (input tx_byte, input tx_first, input cfg, input own_addr,
                output rx_byte, output rx_ack, output done_tgl, output wake_hit);
endinterface
`default_nettype wire

// ===== verilog/i2c_shift_path.sv
// nine-bit shift path clocked by the serial clock pin
`timescale 1ns/1ns
`default_nettype none
`include "i2c_regs_consts.svh"
module i2c_shift_path (
  input wire logic scl_clk,
  input wire logic nrst,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  shift_link_if.link lk
);
  logic [8:0] sh9_r;
  logic [3:0] cnt_r;
  logic drv_r;
  logic [`CFG_W-1:0] cfg_s1_r;
  logic [`CFG_W-1:0] cfg_s2_r;
  logic [7:0] rx_r;
  logic rx_ack_r;
  logic done_r;
  logic wake_r;
  logic ack_en;
  logic wake_ok;
  logic sda_val;

  // config levels only cross on serial clock edges; firmware sets them before traffic
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      cfg_s1_r <= '0;
      cfg_s2_r <= '0;
    end else begin
      cfg_s1_r <= lk.cfg;
      cfg_s2_r <= cfg_s1_r;
    end
  end

  // data enters through the hidden ack flag at sh9_r[0]
  always_ff @(posedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      sh9_r <= 9'h1ff;
      cnt_r <= 4'h0;
      rx_r <= 8'h00;
      rx_ack_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      if (cnt_r == 4'h0) begin
        sh9_r <= {lk.tx_byte[6:0], 1'b1, sda_in};
      end else begin
        sh9_r <= {sh9_r[7:0], sda_in};
      end
      if (cnt_r == `BIT_LAST) begin
        cnt_r <= 4'h0;
        rx_r <= sh9_r[7:0];
        rx_ack_r <= sda_in;
        done_r <= ~done_r;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  assign wake_ok = cfg_s2_r[`CFG_PD] && cfg_s2_r[`CFG_WEN] && i2c_regs_pkg::addr_hit(sh9_r[7:0], lk.own_addr)
    && (sh9_r[0] ? cfg_s2_r[`CFG_WRD] : cfg_s2_r[`CFG_WWR]);
  // ignoring the address while master or while aa is low keeps the bus monitored only
  assign ack_en = wake_ok || (cfg_s2_r[`CFG_RX] && cfg_s2_r[`CFG_AA]
    && (!cfg_s2_r[`CFG_ADRPH] || (!cfg_s2_r[`CFG_MST] && i2c_regs_pkg::addr_hit(sh9_r[7:0], lk.own_addr))));

  // outgoing bits change on falling edges
  always_ff @(negedge scl_clk or negedge nrst) begin
    if (!nrst) begin
      drv_r <= 1'b1;
      wake_r <= 1'b0;
    end else begin
      if (cnt_r == `BIT_LAST) begin
        drv_r <= ~ack_en;
      end else if (cnt_r == 4'h0) begin
        drv_r <= 1'b1;
      end else begin
        drv_r <= cfg_s2_r[`CFG_TX] ? sh9_r[8] : 1'b1;
      end
      if (!cfg_s2_r[`CFG_WEN]) begin
        wake_r <= 1'b0;
      end else if (cnt_r == `BIT_LAST && cfg_s2_r[`CFG_ADRPH] && wake_ok) begin
        wake_r <= 1'b1;
      end
    end
  end

  // first bit comes straight from the buffer the cpu write loaded
  assign sda_val = (cnt_r == 4'h0) ? (cfg_s2_r[`CFG_TX] ? lk.tx_first : 1'b1) : drv_r;
  assign sda_out = 1'b0;
  assign sda_oe = cfg_s2_r[`CFG_ENS] && !sda_val;
  assign lk.rx_byte = rx_r;
  assign lk.rx_ack = rx_ack_r;
  assign lk.done_tgl = done_r;
  assign lk.wake_hit = wake_r;
endmodule // i2c_shift_path
`default_nettype wire

// ===== verification/i2c_far_host.sv
// far-side bus host model: clocks bytes, drives and samples the data line
`timescale 1ns/1ns
`default_nettype none
module i2c_far_host (
  input wire logic sda_oe,
  input wire logic scl_oe,
  output logic scl_clk,
  output logic sda_line
);
  logic scl_drv;
  logic drive_low;
  // open drain with pull-ups: released lines read high
  assign sda_line = !(drive_low || sda_oe);
  assign scl_clk = scl_drv && !scl_oe;
  initial begin
    scl_drv = 1'b1;
    drive_low = 1'b0;
  end
  // nine pulses per byte; clock stands high between frames
  task automatic xfer(input logic [7:0] tx, input logic ack_low, output logic [7:0] seen, output logic ack_line);
    #7;
    for (int i = 0; i < 9; i++) begin
      scl_drv = 1'b0;
      #40;
      drive_low = (i < 8) ? !tx[7 - i] : ack_low;
      #40;
      if (i < 8) seen[7 - i] = sda_line;
      else ack_line = sda_line;
      scl_drv = 1'b1;
      #80;
    end
    drive_low = 1'b0;
  endtask
endmodule // i2c_far_host
`default_nettype wire

// ===== verification/i2c_byte_engine_registers_tb_top.sv
// self-checking bench of the serial interface register block
`timescale 1ns/1ns
`default_nettype none
`include "i2c_regs_consts.svh"
module i2c_byte_engine_registers_tb_top;
  logic core_clk = 1'b0;
  logic nrst;
  logic [15:0] sfr_addr = 16'h0000;
  logic [7:0] sfr_wdata = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_rdata;
  logic bus_event = 1'b0;
  logic [4:0] bus_event_code = 5'h1f;
  logic stop_seen = 1'b0;
  logic master_mode = 1'b0;
  logic rx_mode = 1'b0;
  logic tx_mode = 1'b0;
  logic addr_phase = 1'b0;
  logic power_down = 1'b0;
  logic scl_clk, sda_line, sda_oe, scl_oe;
  logic interface_enable_bit, stop_request_bit, serial_irq, byte_done, ack_seen, own_addr_hit, wake_request;
  logic wake_slave_tx;
  logic start_request_bit, ack_assert_bit, sda_out, scl_out;
  logic [7:0] s;
  logic a;
  int n_errors = 0;
  int n_compared = 0;
  int n_done = 0;
  int cycles = 0;

  i2c_byte_engine_registers dut_u (.core_clk(core_clk), .nrst(nrst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .scl_clk(scl_clk), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_out(scl_out), .scl_oe(scl_oe), .bus_event(bus_event),
    .bus_event_code(bus_event_code),
    .stop_seen(stop_seen), .master_mode(master_mode), .rx_mode(rx_mode), .tx_mode(tx_mode),
    .addr_phase(addr_phase), .power_down(power_down), .interface_enable_bit(interface_enable_bit),
    .start_request_bit(start_request_bit), .stop_request_bit(stop_request_bit), .ack_assert_bit(ack_assert_bit),
    .serial_irq(serial_irq),
    .byte_done(byte_done), .ack_seen(ack_seen), .own_addr_hit(own_addr_hit), .wake_request(wake_request),
    .wake_slave_tx(wake_slave_tx));
  i2c_far_host host_u (.sda_oe(sda_oe), .scl_oe(scl_oe), .scl_clk(scl_clk), .sda_line(sda_line));

  always #20 core_clk = !core_clk;
  // pulse is combinational from flops, so look at it mid-cycle
  always @(negedge core_clk) if (byte_done === 1'b1) n_done++;
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // lowering strobes one edge before the next request avoids double assignment
  task automatic wr(input logic [15:0] ad, input logic [7:0] d);
    sfr_addr <= ad;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge core_clk);
    sfr_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd_chk(input logic [15:0] ad, input logic [7:0] exp);
    sfr_addr <= ad;
    sfr_rd <= 1'b1;
    @(posedge core_clk);
    sfr_rd <= 1'b0;
    @(posedge core_clk);
    chk_byte(sfr_rdata, exp);
  endtask
  task automatic event_pulse(input logic [4:0] code);
    bus_event <= 1'b1;
    bus_event_code <= code;
    @(posedge core_clk);
    bus_event <= 1'b0;
    @(posedge core_clk);
  endtask
  // one frame; a single completion pulse is expected per byte
  task automatic byte_io(input logic [7:0] tx, input logic ack_low);
    int d0;
    d0 = n_done;
    host_u.xfer(tx, ack_low, s, a);
    repeat (6) @(posedge core_clk);
    chk_bit(n_done == d0 + 1, 1'b1);
  endtask

  task automatic t_reset();
    rd_chk(`OFF_STA, `STA_IDLE);
    rd_chk(`OFF_CTRL, 8'h00);
    rd_chk(16'h0123, 8'h00);
    chk_bit(sda_out, 1'b0);
    chk_bit(scl_out, 1'b0);
    wr(`OFF_STA, 8'h00);
    rd_chk(`OFF_STA, `STA_IDLE);
  endtask
  task automatic t_status();
    wr(`OFF_CTRL, 8'h64);
    chk_bit(start_request_bit, 1'b1);
    chk_bit(ack_assert_bit, 1'b1);
    wr(`OFF_CTRL, 8'h44);
    chk_bit(start_request_bit, 1'b0);
    chk_bit(interface_enable_bit, 1'b1);
    event_pulse(5'h0b);
    chk_bit(serial_irq, 1'b1);
    rd_chk(`OFF_STA, 8'h58);
    event_pulse(5'h0c);
    rd_chk(`OFF_STA, 8'h58);
    wr(`OFF_CTRL, 8'h44);
    rd_chk(`OFF_STA, `STA_IDLE);
    // flag clear and new event in the same cycle: hardware wins
    bus_event <= 1'b1;
    bus_event_code <= 5'h0d;
    wr(`OFF_CTRL, 8'h44);
    bus_event <= 1'b0;
    chk_bit(serial_irq, 1'b1);
    rd_chk(`OFF_STA, 8'h68);
    wr(`OFF_CTRL, 8'h54);
    chk_bit(stop_request_bit, 1'b1);
    stop_seen <= 1'b1;
    @(posedge core_clk);
    stop_seen <= 1'b0;
    @(posedge core_clk);
    chk_bit(stop_request_bit, 1'b0);
    wr(`OFF_CTRL, 8'h10);
    chk_bit(stop_request_bit, 1'b0);
    wr(`OFF_CTRL, 8'h44);
  endtask
  // a spare frame first lets config levels reach the link clock domain
  task automatic t_receive();
    rx_mode <= 1'b1;
    byte_io(8'h00, 1'b0);
    byte_io(8'ha5, 1'b0);
    chk_bit(a, 1'b0);
    rd_chk(`OFF_DAT, 8'ha5);
    wr(`OFF_CTRL, 8'h40);
    byte_io(8'h00, 1'b0);
    byte_io(8'h3c, 1'b0);
    chk_bit(a, 1'b1);
    rd_chk(`OFF_DAT, 8'h3c);
    wr(`OFF_CTRL, 8'h44);
  endtask
  task automatic t_address();
    addr_phase <= 1'b1;
    wr(`OFF_ADR, 8'h5b);
    byte_io(8'h00, 1'b0);
    byte_io(8'h5a, 1'b0);
    chk_bit(a, 1'b0);
    chk_bit(own_addr_hit, 1'b1);
    byte_io(8'h00, 1'b0);
    chk_bit(a, 1'b0);
    wr(`OFF_ADR, 8'h5a);
    byte_io(8'h00, 1'b0);
    byte_io(8'h00, 1'b0);
    chk_bit(a, 1'b1);
    master_mode <= 1'b1;
    byte_io(8'h00, 1'b0);
    byte_io(8'h5a, 1'b0);
    chk_bit(a, 1'b1);
    master_mode <= 1'b0;
    rd_chk(`OFF_ADR, 8'h5a);
  endtask
  task automatic t_transmit();
    rx_mode <= 1'b0;
    tx_mode <= 1'b1;
    addr_phase <= 1'b0;
    byte_io(8'hff, 1'b1);
    event_pulse(5'h14);
    // bit 7 low so the first driven bit must come from the write buffer
    wr(`OFF_DAT, 8'h43);
    // far side pulls bit 6 low, as a master winning arbitration would
    byte_io(8'hbf, 1'b1);
    chk_byte(s, 8'h43 & 8'hbf);
    chk_bit(ack_seen, 1'b0);
    rd_chk(`OFF_DAT, 8'h43 & 8'hbf);
    wr(`OFF_CTRL, 8'h44);
    wr(`OFF_DAT, 8'h11);
    rd_chk(`OFF_DAT, 8'h43 & 8'hbf);
  endtask
  task automatic t_wake();
    tx_mode <= 1'b0;
    rx_mode <= 1'b1;
    addr_phase <= 1'b1;
    wr(`OFF_WAKE, 8'h03);
    power_down <= 1'b1;
    byte_io(8'h00, 1'b0);
    byte_io(8'h5a, 1'b0);
    chk_bit(a, 1'b0);
    chk_bit(wake_request, 1'b1);
    chk_bit(scl_oe, 1'b1);
    chk_bit(wake_slave_tx, 1'b0);
    wr(`OFF_WAKE, 8'h00);
    // hold releases one clock after the enable bit drops
    @(posedge core_clk);
    chk_bit(wake_request, 1'b0);
    chk_bit(scl_oe, 1'b0);
  endtask

  initial begin
    nrst <= 1'b0;
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    t_reset();
    t_status();
    t_receive();
    t_address();
    t_transmit();
    t_wake();
    complete_run();
  end
endmodule // i2c_byte_engine_registers_tb_top
`default_nettype wire
